// [ssr_bus_model.sv]
// Data bus as the bus master sees it; a released line shows the inverse of its last value.
`timescale 1ns/1ps
module ssr_bus_model (
	input wire logic mclk_i,
	input wire logic [35:0] dq_o,
	input wire logic dq_oe_n_o,
	output logic [35:0] bus_o
);
	logic [35:0] last = 36'h0;
	always @(posedge mclk_i) if (!dq_oe_n_o) last <= dq_o;
	assign bus_o = dq_oe_n_o ? ~last : dq_o;
endmodule

// [ssr_checker.sv]
// Checker on the ports of the burst memory core.
`timescale 1ns/1ps
module ssr_checker (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire ssr_pkg::ssr_ctl_t ctl_i,
	input wire logic out_enable_n_i,
	input wire logic [ssr_pkg::DATA_W-1:0] dq_o,
	input wire logic dq_oe_n_o,
	input wire logic ready_o,
	input wire logic sleeping_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	wire s = !ctl_i.chip_sel_first_n & ctl_i.chip_sel_high_active & !ctl_i.chip_sel_third_n;
	wire p = !ctl_i.processor_addr_strobe_n;
	wire c = !ctl_i.controller_addr_strobe_n;
	wire g = ready_o & !ctl_i.sleep_request & !sleeping_o;
	wire q = g & ctl_i.global_write_n & ctl_i.byte_write_gate_n & ctl_i.burst_advance_n;
	sequence s_rd; g & s & p; endsequence
	property p_sel; g & !s & (p | c) |=> dq_oe_n_o; endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_rd; s_rd ##1 !out_enable_n_i |-> !dq_oe_n_o; endproperty
	a_rd: assert property (p_rd) else $error("first read");
	property p_hold; q & !dq_oe_n_o & !p & !c |=> $stable(dq_o); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_wr; g & s & c & !p & !ctl_i.global_write_n |=> dq_oe_n_o; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_hiz; !out_enable_n_i & dq_oe_n_o & !p & !c |=> dq_oe_n_o; endproperty
	a_hiz: assert property (p_hiz) else $error("high z");
	property p_wake; $fell(sleeping_o) |-> dq_oe_n_o; endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_rdy; !ready_o |-> dq_oe_n_o; endproperty
	a_rdy: assert property (p_rdy) else $error("ready");
endmodule
bind ssr_core ssr_checker u_chk (.mclk_i, .rst_i, .ctl_i, .out_enable_n_i, .dq_o, .dq_oe_n_o,
	.ready_o, .sleeping_o);

// [ssr_core.sv]
// Bus-side logic of a synchronous flow-through burst memory.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] The bus master waits at least one millisecond after power-up before its first access.
// [RULE2] The memory is selected only with first enable low, second high and third low.
// [RULE3] Byte-lane writes are ignored in the first cycle of a burst started by the processor strobe.
// [RULE4] With advance inactive the burst address holds until advance returns.
// [RULE5] All bytes are written when global write is low, or gate and all lanes are low.
// [RULE6] After a write the data outputs stay high impedance until a strobe starts a new read.
// [RULE7] The bus master deselects the memory before it asserts sleep.
// [RULE8] On leaving sleep the data lines are high impedance.
// [RULE9] A strobe with the chip selected registers the address; a two-bit counter steps later ones.
module ssr_core #(
	parameter int ADDR_W = ssr_pkg::ADDR_W,
	parameter int DATA_W = ssr_pkg::DATA_W,
	parameter int POWERUP_CYCLES = ssr_pkg::POWERUP_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire ssr_pkg::ssr_ctl_t ctl_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] dq_i,
	input wire logic out_enable_n_i,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_n_o,
	output logic ready_o,
	output logic sleeping_o
);
	localparam int LW = ssr_pkg::LANE_W;
	localparam int NL = ssr_pkg::LANES;
	localparam int BW = ssr_pkg::BURST_W;
	localparam int DW = ssr_pkg::DEPTH_W;

	logic [LW-1:0] mem [0:NL-1][0:(1<<DW)-1];
	logic [31:0] pwr_cnt;
	logic [31:0] next_pwr_cnt;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] next_base;
	logic [BW-1:0] cnt;
	logic [BW-1:0] next_cnt;
	ssr_pkg::ssr_state_t state;
	ssr_pkg::ssr_state_t next_state;
	logic [DATA_W-1:0] rd;
	logic [DATA_W-1:0] next_rd;
	ssr_pkg::ssr_wr_t buf_q [0:1];
	ssr_pkg::ssr_wr_t next_buf0;
	ssr_pkg::ssr_wr_t next_buf1;
	logic [1:0] buf_n;
	logic [1:0] next_buf_n;
	logic selected;
	logic strobe;
	logic start;
	logic in_burst;
	logic [NL-1:0] lanes;
	logic [BW-1:0] step_cnt;
	logic [ADDR_W-1:0] step_addr;
	logic [DW-1:0] rd_addr;
	logic [DATA_W-1:0] rd_word;
	logic wr_valid;
	logic wr_ready;
	logic drain;
	ssr_pkg::ssr_wr_t wr_word;

	function automatic logic [NL-1:0] lane_decode(input ssr_pkg::ssr_ctl_t c);
		if (!c.global_write_n)
			lane_decode = {NL{1'b1}}; // RULE5
		else if (!c.byte_write_gate_n)
			lane_decode = ~c.byte_lane_writes_n; // RULE5
		else
			lane_decode = {NL{1'b0}};
	endfunction

	assign selected = !ctl_i.chip_sel_first_n && ctl_i.chip_sel_high_active
		&& !ctl_i.chip_sel_third_n; // RULE2
	assign strobe = !ctl_i.processor_addr_strobe_n || !ctl_i.controller_addr_strobe_n;
	assign start = strobe && selected && ready_o && !ctl_i.sleep_request
		&& (state != ssr_pkg::SSR_SLEEP); // RULE9
	assign in_burst = (state == ssr_pkg::SSR_READ) || (state == ssr_pkg::SSR_WRITE);
	assign step_cnt = ctl_i.burst_advance_n ? cnt : cnt + 2'h1; // RULE4
	assign step_addr = {base[ADDR_W-1:BW], base[BW-1:0] + step_cnt};
	assign rd_addr = start ? addr_i[DW-1:0] : step_addr[DW-1:0];
	assign lanes = lane_decode(ctl_i);
	assign ready_o = (pwr_cnt == 32'h0); // RULE1
	assign wr_ready = (buf_n != 2'h2);
	assign wr_word.lanes = lanes;
	assign wr_word.addr = strobe ? addr_i : step_addr;
	assign wr_word.data = dq_i;
	assign sleeping_o = (state == ssr_pkg::SSR_SLEEP);
	assign dq_o = rd;
	assign dq_oe_n_o = !(state == ssr_pkg::SSR_READ && !out_enable_n_i); // RULE6 RULE8
	assign drain = (buf_n != 2'h0);

	always_comb
	begin
		wr_valid = 1'b0;
		if (ready_o && !ctl_i.sleep_request && state != ssr_pkg::SSR_SLEEP && (|lanes))
		begin
			if (!ctl_i.processor_addr_strobe_n)
				wr_valid = 1'b0; // RULE3
			else if (strobe)
				wr_valid = selected; // RULE2
			else
				wr_valid = in_burst;
		end
	end

	always_comb
	begin
		next_pwr_cnt = pwr_cnt;
		if (pwr_cnt != 32'h0)
			next_pwr_cnt = pwr_cnt - 32'h1; // RULE1
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pwr_cnt <= 32'(POWERUP_CYCLES);
		else
			pwr_cnt <= next_pwr_cnt;
	end

	always_comb
	begin
		next_base = base;
		next_cnt = cnt;
		next_state = state;
		next_rd = rd;
		if (ctl_i.sleep_request)
			next_state = ssr_pkg::SSR_SLEEP;
		else
		begin
			case (state)
				ssr_pkg::SSR_SLEEP:
					next_state = ssr_pkg::SSR_IDLE; // RULE8
				default:
				begin
					if (start)
					begin
						next_base = addr_i; // RULE9
						next_cnt = ssr_pkg::BURST_RST;
						next_rd = rd_word;
						if (!ctl_i.processor_addr_strobe_n)
							next_state = ssr_pkg::SSR_READ; // RULE3
						else if (|lanes)
							next_state = ssr_pkg::SSR_WRITE; // RULE6
						else
							next_state = ssr_pkg::SSR_READ; // RULE6
					end
					else if (strobe && !selected)
						next_state = ssr_pkg::SSR_IDLE; // RULE2
					else if (in_burst)
					begin
						if (!ctl_i.burst_advance_n)
							next_cnt = step_cnt; // RULE9
						else
							next_cnt = cnt; // RULE4
						if (|lanes)
							next_state = ssr_pkg::SSR_WRITE; // RULE6
						next_rd = rd_word;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			base <= '0;
			cnt <= ssr_pkg::BURST_RST;
			state <= ssr_pkg::SSR_IDLE;
			rd <= '0;
		end
		else
		begin
			base <= next_base;
			cnt <= next_cnt;
			state <= next_state;
			rd <= next_rd;
		end
	end

	always_comb
	begin
		next_buf0 = buf_q[0];
		next_buf1 = buf_q[1];
		next_buf_n = buf_n;
		if (drain)
		begin
			next_buf0 = buf_q[1];
			next_buf_n = buf_n - 2'h1;
		end
		if (wr_valid && wr_ready)
		begin
			if (next_buf_n == 2'h0)
				next_buf0 = wr_word;
			else
				next_buf1 = wr_word;
			next_buf_n = next_buf_n + 2'h1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			buf_n <= 2'h0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end
		else
		begin
			buf_n <= next_buf_n;
			buf_q[0] <= next_buf0;
			buf_q[1] <= next_buf1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NL; g++)
		begin : g_lane
			logic hit;
			assign hit = drain && buf_q[0].lanes[g] && (buf_q[0].addr[DW-1:0] == rd_addr);
			assign rd_word[g*LW +: LW] = hit ? buf_q[0].data[g*LW +: LW] : mem[g][rd_addr];
			always_ff @(posedge mclk_i)
			begin
				if (drain && buf_q[0].lanes[g])
					mem[g][buf_q[0].addr[DW-1:0]] <= buf_q[0].data[g*LW +: LW];
			end
		end
	endgenerate
endmodule

// [ssr_pkg.sv]
// Package with constants and carrier types for the synchronous burst memory.
package ssr_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int BURST_W = 2;
	localparam int DEPTH_W = 8;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int POWERUP_WAIT_MS = 1;
	localparam int POWERUP_CYCLES = (POWERUP_WAIT_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

	typedef struct packed {
		logic processor_addr_strobe_n;
		logic controller_addr_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_gate_n;
		logic [LANES-1:0] byte_lane_writes_n;
		logic chip_sel_first_n;
		logic chip_sel_high_active;
		logic chip_sel_third_n;
		logic sleep_request;
	} ssr_ctl_t;

	typedef struct packed {
		logic [LANES-1:0] lanes;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ssr_wr_t;

	typedef enum logic [1:0] {
		SSR_IDLE = 2'h0,
		SSR_READ = 2'h1,
		SSR_WRITE = 2'h2,
		SSR_SLEEP = 2'h3
	} ssr_state_t;
endpackage

// [tb_ssr_core.sv]
// Self-checking bench for the burst memory core.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module tb_ssr_core;
	localparam ssr_pkg::ssr_ctl_t IDLE = 13'h1ff4;
	logic mclk_i = 0, rst_i = 1, oe_n = 0, dq_oe_n_o, ready_o, sleeping_o;
	logic [17:0] addr = 18'h0, b;
	logic [35:0] dq = 36'h0, dq_o, bus, ex [4];
	ssr_pkg::ssr_ctl_t ctl = IDLE, sel = IDLE, c;
	int bad_count = 0, n_compared = 0, cyc = 0;
	always #5 mclk_i = ~mclk_i;
	ssr_core #(.POWERUP_CYCLES(4)) u_dut (.mclk_i, .rst_i, .ctl_i(ctl), .addr_i(addr),
		.dq_i(dq), .out_enable_n_i(oe_n), .dq_o, .dq_oe_n_o, .ready_o, .sleeping_o);
	ssr_bus_model u_bus (.mclk_i, .dq_o, .dq_oe_n_o, .bus_o(bus));
	task automatic step(input ssr_pkg::ssr_ctl_t k, input logic [17:0] a, input logic [35:0] d);
		@(posedge mclk_i);
		ctl <= k;
		addr <= a;
		dq <= d;
		#1;
	endtask
	task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic g);
		c = sel;
		c.controller_addr_strobe_n = 0;
		if (g) {c.byte_write_gate_n, c.byte_lane_writes_n} = 5'h0;
		else c.global_write_n = 0;
		step(c, a, d);
	endtask
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			bad_count++;
			close_out();
		end
	end
	initial
	begin
		void'($urandom(42618));
		repeat (2) @(posedge mclk_i);
		rst_i <= 0;
		while (ready_o !== 1'b1) step(IDLE, 18'h0, 36'h0);
		for (int t = 0; t < 6; t++)
		begin
			b = 18'($urandom_range(63)) << 2;
			for (int i = 0; i < 4; i++)
			begin
				ex[i] = 36'({$urandom, $urandom});
				wr(b + 18'(i), ex[i], t[0]);
			end
			if (t > 2)
			begin
				sel[t-2] = ~sel[t-2];
				wr(b, ~ex[0], t[0]);
				sel = IDLE;
			end
			`CHK(dq_oe_n_o, 1'b1)
			c = IDLE;
			c.processor_addr_strobe_n = 0;
			{c.byte_write_gate_n, c.byte_lane_writes_n} = 5'h0;
			repeat (2)
			begin
				step(c, b, ~ex[0]);
				for (int i = 0; i < 4; i++)
				begin
					step(i[0] ? IDLE : IDLE ^ 13'h400, 18'h0, 36'h0);
					`CHK(bus, ex[(i + 1) / 2])
				end
			end
			$display("test %0d done", t);
		end
		c = IDLE;
		c.chip_sel_first_n = 1;
		step(c, 18'h0, 36'h0);
		c.sleep_request = 1;
		repeat (3) step(c, 18'h0, 36'h0);
		`CHK(sleeping_o, 1'b1)
		c.sleep_request = 0;
		repeat (2) step(c, 18'h0, 36'h0);
		`CHK({sleeping_o, dq_oe_n_o}, 2'b01)
		$display("test sleep done");
		close_out();
	end
endmodule
